// ---- shared/ias_pkg.sv ----
/*
  Shared constants and types for the two-wire result slave of a 12-bit converter.
  Assumes a 200 MHz core clock and a free-running link sampling clock.
*/
package ias_pkg;
  localparam int           IAS_RES_W        = 12;
  localparam int           IAS_CNT_W        = 12;
  localparam int           IAS_BIT_W        = 4;
  localparam int           IAS_CLK_PERIOD_NS = 5;
  localparam int           IAS_ACQ_TIME_NS  = 1120;
  localparam int           IAS_CONV_TIME_NS = 8960;
  localparam int           IAS_ACQ_CYCLES   = (IAS_ACQ_TIME_NS + IAS_CLK_PERIOD_NS - 1) / IAS_CLK_PERIOD_NS;
  localparam int           IAS_CONV_CYCLES  = (IAS_CONV_TIME_NS + IAS_CLK_PERIOD_NS - 1) / IAS_CLK_PERIOD_NS;
  localparam logic [2:0]   IAS_ADDR_SEL_DEFAULT = 3'h5;
  localparam logic [3:0]   IAS_ADDR_BITS    = 4'h8;
  localparam logic [3:0]   IAS_LAST_BIT     = 4'h7;
  localparam logic [3:0]   IAS_ZERO_LAST    = 4'h3;
  localparam logic [3:0]   IAS_NIBBLE_FIRST = 4'h4;
  localparam logic [3:0]   IAS_UPPER_TOP    = 4'hF;
  localparam logic [3:0]   IAS_BIT_ZERO     = 4'h0;

  typedef enum logic [2:0] {
    IAS_ST_IDLE     = 3'h0,
    IAS_ST_ADDR     = 3'h1,
    IAS_ST_ADDR_ACK = 3'h2,
    IAS_ST_TX       = 3'h3,
    IAS_ST_MACK     = 3'h4,
    IAS_ST_IGNORE   = 3'h5
  } ias_link_state_e;

  typedef enum logic [1:0] {
    IAS_CV_IDLE = 2'h0,
    IAS_CV_ACQ  = 2'h1,
    IAS_CV_CONV = 2'h2
  } ias_conv_state_e;
endpackage : ias_pkg

// ---- shared/ias_conv_if.sv ----
/*
  Carrier between the link controller and the converter core.
  All signals belong to the core clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface ias_conv_if;
  logic                          conv_start;
  logic [ias_pkg::IAS_RES_W-1:0] result;
  logic                          done_tgl;
  logic                          busy;

  modport ctrl (output conv_start, input result, input done_tgl, input busy);
  modport core (input conv_start, output result, output done_tgl, output busy);
endinterface : ias_conv_if
`default_nettype wire

// ---- design/ias_converter.sv ----
/*
  Self-timed sample, hold and conversion sequencer with its result register.
  Assumes conv_start is a one-cycle pulse on clk_in; sample_in stands for the analog level.
*/
`timescale 1ns/100ps
`default_nettype none
module ias_converter #(
  parameter int ACQ_CYCLES  = ias_pkg::IAS_ACQ_CYCLES,
  parameter int CONV_CYCLES = ias_pkg::IAS_CONV_CYCLES
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [ias_pkg::IAS_RES_W-1:0] sample_in,
  ias_conv_if.core                           cv
);
  import ias_pkg::*;

  if (ACQ_CYCLES < 1 || CONV_CYCLES < 1 || ACQ_CYCLES >= (1 << IAS_CNT_W) || CONV_CYCLES >= (1 << IAS_CNT_W))
  begin : g_bad_timing
    $error("converter timing counts out of range");
  end

  ias_conv_state_e        state_reg,  state_next;
  logic [IAS_CNT_W-1:0]   cnt_reg,    cnt_next;
  logic [IAS_RES_W-1:0]   hold_reg,   hold_next;
  logic [IAS_RES_W-1:0]   result_reg, result_next;
  logic                   done_reg,   done_next;

  wire acq_end  = (state_reg == IAS_CV_ACQ) && (cnt_reg == IAS_CNT_W'(ACQ_CYCLES - 1));
  wire conv_end = (state_reg == IAS_CV_CONV) && (cnt_reg == IAS_CNT_W'(CONV_CYCLES - 1));
  wire [IAS_CNT_W-1:0] cnt_inc = cnt_reg + 1'b1;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_inc;
    hold_next   = hold_reg;
    result_next = result_reg;
    done_next   = done_reg;
    case (state_reg)
      IAS_CV_IDLE: cnt_next = '0;
      IAS_CV_ACQ: begin
        if (acq_end) begin
          hold_next  = sample_in;
          cnt_next   = '0;
          state_next = IAS_CV_CONV;
        end
      end
      IAS_CV_CONV: begin
        if (conv_end) begin
          result_next = hold_reg;
          done_next   = ~done_reg;
          state_next  = IAS_CV_IDLE;
        end
      end
      default: state_next = IAS_CV_IDLE;
    endcase
    if (cv.conv_start) begin
      state_next = IAS_CV_ACQ;
      cnt_next   = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg  <= IAS_CV_IDLE;
      cnt_reg    <= '0;
      hold_reg   <= '0;
      result_reg <= '0;
      done_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      hold_reg   <= hold_next;
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  assign cv.result   = result_reg;
  assign cv.done_tgl = done_reg;
  assign cv.busy     = (state_reg != IAS_CV_IDLE);

  a_start_restarts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cv.conv_start |=> (state_reg == IAS_CV_ACQ) && (cnt_reg == '0))
    else $error("conversion request did not start acquisition");
  a_result_on_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(result_reg) |-> $changed(done_reg) && $past(state_reg) == IAS_CV_CONV)
    else $error("result changed without a finished conversion");
endmodule : ias_converter
`default_nettype wire

// ---- design/ias_result_slave.sv ----
/*
  Two-wire slave returning converter results, with the converter core attached.
  Assumes link_clk_in free-runs well above the serial clock; scl_in and sda_in are pin levels.
  The link logic oversamples the pins on link_clk_in; the core runs on clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module ias_result_slave #(
  parameter logic [3:0] DEVICE_CODE     = 4'h6, // arbitrary value
  parameter logic       addr_select_hi  = ias_pkg::IAS_ADDR_SEL_DEFAULT[2],
  parameter logic       addr_select_mid = ias_pkg::IAS_ADDR_SEL_DEFAULT[1],
  parameter logic       addr_select_lo  = ias_pkg::IAS_ADDR_SEL_DEFAULT[0],
  parameter int         ACQ_CYCLES      = ias_pkg::IAS_ACQ_CYCLES,
  parameter int         CONV_CYCLES     = ias_pkg::IAS_CONV_CYCLES
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          link_clk_in,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output var  logic                          sda_out,
  output var  logic                          sda_oe_out,
  input  wire logic [ias_pkg::IAS_RES_W-1:0] sample_in,
  output var  logic [ias_pkg::IAS_RES_W-1:0] result_out,
  output var  logic                          busy_out
);
  import ias_pkg::*;

  // drive enable for one result bit: high pulls the line low
  function automatic logic ias_tx_drive(input logic byte_sel, input logic [IAS_BIT_W-1:0] idx,
                                        input logic [IAS_RES_W-1:0] data);
    logic bit_val;
    bit_val = 1'b0;
    if (byte_sel)
      bit_val = data[IAS_LAST_BIT - idx];
    else if (idx >= IAS_NIBBLE_FIRST)
      bit_val = data[IAS_UPPER_TOP - idx];
    return ~bit_val;
  endfunction : ias_tx_drive

  ias_conv_if cv ();

  ias_converter #(
    .ACQ_CYCLES  (ACQ_CYCLES),
    .CONV_CYCLES (CONV_CYCLES)
  ) u_converter (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .sample_in (sample_in),
    .cv        (cv.core)
  );

  // ---------------- core clock domain ----------------
  logic                 req_s1_reg, req_s2_reg, req_s3_reg;
  logic [IAS_RES_W-1:0] result_out_reg;
  logic                 busy_reg;
  logic                 conv_req_tgl_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_s1_reg     <= 1'b0;
      req_s2_reg     <= 1'b0;
      req_s3_reg     <= 1'b0;
      result_out_reg <= '0;
      busy_reg       <= 1'b0;
    end else begin
      req_s1_reg     <= conv_req_tgl_reg;
      req_s2_reg     <= req_s1_reg;
      req_s3_reg     <= req_s2_reg;
      result_out_reg <= cv.result;
      busy_reg       <= cv.busy;
    end
  end

  assign cv.conv_start = req_s2_reg ^ req_s3_reg;
  assign result_out    = result_out_reg;
  assign busy_out      = busy_reg;

  // ---------------- link clock domain ----------------
  logic link_rst_s1_reg, link_rst_n_reg;

  always_ff @(posedge link_clk_in) begin
    link_rst_s1_reg <= rst_n_in;
    link_rst_n_reg  <= link_rst_s1_reg;
  end

  logic                 scl_s1_reg, scl_s2_reg, scl_prev_reg;
  logic                 sda_s1_reg, sda_s2_reg, sda_prev_reg;
  logic                 done_s1_reg, done_s2_reg, done_s3_reg;
  logic [IAS_RES_W-1:0] res_link_reg;

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n_reg) begin
      scl_s1_reg   <= 1'b1;
      scl_s2_reg   <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_s1_reg   <= 1'b1;
      sda_s2_reg   <= 1'b1;
      sda_prev_reg <= 1'b1;
      done_s1_reg  <= 1'b0;
      done_s2_reg  <= 1'b0;
      done_s3_reg  <= 1'b0;
    end else begin
      scl_s1_reg   <= scl_in;
      scl_s2_reg   <= scl_s1_reg;
      scl_prev_reg <= scl_s2_reg;
      sda_s1_reg   <= sda_in;
      sda_s2_reg   <= sda_s1_reg;
      sda_prev_reg <= sda_s2_reg;
      done_s1_reg  <= cv.done_tgl;
      done_s2_reg  <= done_s1_reg;
      done_s3_reg  <= done_s2_reg;
    end
  end

  // result word is held stable by the core long after its toggle, so capture is safe
  wire done_evt = done_s2_reg ^ done_s3_reg;

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n_reg)
      res_link_reg <= '0;
    else if (done_evt)
      res_link_reg <= cv.result;
  end

  // bus conditions, decoded from the synchronised pin levels
  wire scl_high  = scl_s2_reg & scl_prev_reg;
  wire scl_rise  = scl_s2_reg & ~scl_prev_reg;
  wire scl_fall  = ~scl_s2_reg & scl_prev_reg;
  wire start_det = scl_high & sda_prev_reg & ~sda_s2_reg;
  wire stop_det  = scl_high & ~sda_prev_reg & sda_s2_reg;

  ias_link_state_e      state_reg,    state_next;
  logic [IAS_BIT_W-1:0] bit_cnt_reg,  bit_cnt_next;
  logic [7:0]           rx_reg,       rx_next;
  logic                 byte_sel_reg, byte_sel_next;
  logic                 sda_oe_reg,   sda_oe_next;
  logic                 mack_reg,     mack_next;
  logic                 conv_req_tgl_next;
  logic [IAS_RES_W-1:0] res_hold_reg, res_hold_next;

  wire [6:0]           own_addr   = {DEVICE_CODE, addr_select_hi, addr_select_mid, addr_select_lo};
  wire                 addr_match = (rx_reg[7:1] == own_addr);
  wire                 rw_read    = rx_reg[0];
  wire                 addr_done  = (bit_cnt_reg == IAS_ADDR_BITS);
  wire                 last_bit   = (bit_cnt_reg == IAS_LAST_BIT);
  wire [IAS_BIT_W-1:0] bit_inc    = bit_cnt_reg + 1'b1;
  // upper nibble is latched as its first bit goes out, so both bytes come from one result
  wire                 nibble_cap = ~byte_sel_reg & (bit_cnt_reg == IAS_ZERO_LAST);
  wire [IAS_RES_W-1:0] tx_data    = nibble_cap ? res_link_reg : res_hold_reg;

  always_comb begin
    state_next        = state_reg;
    bit_cnt_next      = bit_cnt_reg;
    rx_next           = rx_reg;
    byte_sel_next     = byte_sel_reg;
    sda_oe_next       = sda_oe_reg;
    mack_next         = mack_reg;
    conv_req_tgl_next = conv_req_tgl_reg;
    res_hold_next     = res_hold_reg;
    if (start_det) begin
      state_next   = IAS_ST_ADDR;
      bit_cnt_next = IAS_BIT_ZERO;
      sda_oe_next  = 1'b0;
    end else if (stop_det) begin
      state_next  = IAS_ST_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        IAS_ST_IDLE, IAS_ST_IGNORE: sda_oe_next = 1'b0;
        IAS_ST_ADDR: begin
          if (scl_rise && !addr_done) begin
            rx_next      = {rx_reg[6:0], sda_s2_reg};
            bit_cnt_next = bit_inc;
          end else if (scl_fall && addr_done) begin
            if (addr_match) begin
              state_next  = IAS_ST_ADDR_ACK;
              sda_oe_next = 1'b1;
              if (rw_read)
                conv_req_tgl_next = ~conv_req_tgl_reg;
            end else begin
              state_next = IAS_ST_IGNORE;
            end
          end
        end
        IAS_ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_read) begin
              state_next    = IAS_ST_TX;
              bit_cnt_next  = IAS_BIT_ZERO;
              byte_sel_next = 1'b0;
              sda_oe_next   = ias_tx_drive(1'b0, IAS_BIT_ZERO, res_hold_reg);
            end else begin
              state_next  = IAS_ST_IGNORE;
              sda_oe_next = 1'b0;
            end
          end
        end
        IAS_ST_TX: begin
          if (scl_fall) begin
            if (last_bit) begin
              state_next  = IAS_ST_MACK;
              sda_oe_next = 1'b0;
              if (byte_sel_reg)
                conv_req_tgl_next = ~conv_req_tgl_reg;
            end else begin
              bit_cnt_next  = bit_inc;
              res_hold_next = tx_data;
              sda_oe_next   = ias_tx_drive(byte_sel_reg, bit_inc, tx_data);
            end
          end
        end
        IAS_ST_MACK: begin
          if (scl_rise)
            mack_next = sda_s2_reg;
          else if (scl_fall) begin
            if (!mack_reg) begin
              state_next    = IAS_ST_TX;
              bit_cnt_next  = IAS_BIT_ZERO;
              byte_sel_next = ~byte_sel_reg;
              sda_oe_next   = ias_tx_drive(~byte_sel_reg, IAS_BIT_ZERO, res_hold_reg);
            end else begin
              state_next  = IAS_ST_IGNORE;
              sda_oe_next = 1'b0;
            end
          end
        end
        default: begin
          state_next  = IAS_ST_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n_reg) begin
      state_reg        <= IAS_ST_IDLE;
      bit_cnt_reg      <= IAS_BIT_ZERO;
      rx_reg           <= '0;
      byte_sel_reg     <= 1'b0;
      sda_oe_reg       <= 1'b0;
      mack_reg         <= 1'b1;
      conv_req_tgl_reg <= 1'b0;
      res_hold_reg     <= '0;
    end else begin
      state_reg        <= state_next;
      bit_cnt_reg      <= bit_cnt_next;
      rx_reg           <= rx_next;
      byte_sel_reg     <= byte_sel_next;
      sda_oe_reg       <= sda_oe_next;
      mack_reg         <= mack_next;
      conv_req_tgl_reg <= conv_req_tgl_next;
      res_hold_reg     <= res_hold_next;
    end
  end

  // open drain: only ever pulls low, never touches the clock line
  logic sda_out_reg;

  always_ff @(posedge link_clk_in) begin
    sda_out_reg <= 1'b0;
  end

  assign sda_out    = sda_out_reg;
  assign sda_oe_out = sda_oe_reg;

  // ---------------- checks ----------------
  a_start_to_addr: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    start_det |=> (state_reg == IAS_ST_ADDR) && (bit_cnt_reg == IAS_BIT_ZERO) && !sda_oe_reg)
    else $error("start did not restart address reception");
  a_stop_to_idle: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    stop_det |=> (state_reg == IAS_ST_IDLE) && !sda_oe_reg)
    else $error("stop did not release the bus");
  a_addr_ack_low: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR && scl_fall && addr_done && addr_match)
    |=> (state_reg == IAS_ST_ADDR_ACK) && sda_oe_reg)
    else $error("matching address not acknowledged");
  a_ack_held_low: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR_ACK) |-> sda_oe_reg)
    else $error("acknowledge released early");
  a_read_starts: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR && scl_fall && addr_done && addr_match && rw_read)
    |=> conv_req_tgl_reg != $past(conv_req_tgl_reg))
    else $error("read address did not request a conversion");
  a_poll_no_conv: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR_ACK && !rw_read) |=> $stable(conv_req_tgl_reg))
    else $error("presence poll requested a conversion");
  a_miss_release: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_IGNORE || state_reg == IAS_ST_IDLE || state_reg == IAS_ST_MACK) |-> !sda_oe_reg)
    else $error("data line driven while it should be released");
  a_zero_nibble: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_TX && !byte_sel_reg && bit_cnt_reg < IAS_NIBBLE_FIRST) |-> sda_oe_reg)
    else $error("leading zero bit not driven low");
  a_tx_bit_value: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_TX) |-> sda_oe_reg == ias_tx_drive(byte_sel_reg, bit_cnt_reg, res_hold_reg))
    else $error("result bit on the line is wrong");
  a_lsb_restarts: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_TX && byte_sel_reg && last_bit && scl_fall && !start_det && !stop_det)
    |=> (conv_req_tgl_reg != $past(conv_req_tgl_reg)) && (state_reg == IAS_ST_MACK))
    else $error("least bit did not start the next sampling");
  a_nack_ends: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_MACK && scl_fall && mack_reg) |=> (state_reg == IAS_ST_IGNORE) && !sda_oe_reg)
    else $error("missing master acknowledge did not end the read");
  a_miss_ignored: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR && scl_fall && addr_done && !addr_match)
    |=> (state_reg == IAS_ST_IGNORE) && !sda_oe_reg)
    else $error("unmatched address was not ignored");
  a_addr_listen: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR) |-> !sda_oe_reg)
    else $error("data line driven during the address byte");
  a_addr_shift: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR && scl_rise && !addr_done)
    |=> (bit_cnt_reg == $past(bit_cnt_reg) + 1'b1) && (rx_reg[0] == $past(sda_s2_reg)))
    else $error("address bit not taken on the clock rise");
  a_poll_releases: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR_ACK && scl_fall && !rw_read)
    |=> (state_reg == IAS_ST_IGNORE) && !sda_oe_reg)
    else $error("presence poll did not release the bus");
  a_read_to_data: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_ADDR_ACK && scl_fall && rw_read)
    |=> (state_reg == IAS_ST_TX) && (bit_cnt_reg == IAS_BIT_ZERO) && !byte_sel_reg && sda_oe_reg)
    else $error("read acknowledge not followed by the first result byte");
  a_tx_steady: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_TX && !scl_fall && !start_det && !stop_det) |=> $stable(sda_oe_reg))
    else $error("data drive changed away from a clock fall");
  a_nibble_latch: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_TX && !byte_sel_reg && bit_cnt_reg == IAS_ZERO_LAST && scl_fall)
    |=> res_hold_reg == $past(res_link_reg))
    else $error("result word not latched before the upper nibble");
  a_byte_release: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_TX && last_bit && scl_fall) |=> (state_reg == IAS_ST_MACK) && !sda_oe_reg)
    else $error("data line not released for the master acknowledge");
  a_mack_continues: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    (state_reg == IAS_ST_MACK && scl_fall && !mack_reg)
    |=> (state_reg == IAS_ST_TX) && (bit_cnt_reg == IAS_BIT_ZERO) && (byte_sel_reg != $past(byte_sel_reg)))
    else $error("master acknowledge did not continue the transfer");
  a_link_capture: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_reg)
    done_evt |=> res_link_reg == $past(cv.result))
    else $error("finished result not copied into the link domain");
  a_req_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cv.conv_start |=> !cv.conv_start)
    else $error("conversion request longer than one cycle");
  a_busy_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cv.conv_start |=> ##1 busy_reg)
    else $error("busy output did not follow a conversion request");
endmodule : ias_result_slave
`default_nettype wire

// ---- verif/ias_i2c_master.sv ----
/*
  Behavioural two-wire bus master driving the result slave.
  Assumes clk_in is the 5 ns core clock; SDA has a pull-up, the slave only pulls low.
*/
`timescale 1ns/100ps
`default_nettype none
module ias_i2c_master (
  input  wire logic clk_in,
  input  wire logic sda_oe_in,
  output var  logic scl_out,
  output var  logic sda_line_out
);
  logic m_sda;
  // open drain wire: pull-up, low if anyone pulls
  assign sda_line_out = m_sda & !sda_oe_in;
  initial begin
    m_sda   = 1'b1;
    scl_out = 1'b1;
  end
  // half bit of 750 ns, six link cycles
  task automatic half();
    repeat (150) @(negedge clk_in);
  endtask : half
  task automatic start();
    m_sda = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    m_sda = 1'b0;
    half();
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    m_sda = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    m_sda = 1'b1;
    half();
  endtask : stop
  // data changes only while the clock is low
  task automatic bitx(input logic b, output logic r);
    m_sda = b;
    half();
    scl_out = 1'b1;
    repeat (75) @(negedge clk_in);
    r = sda_line_out;
    repeat (75) @(negedge clk_in);
    scl_out = 1'b0;
  endtask : bitx
  // eight bits msb first, then the acknowledge pulse
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_q);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ack_in, ack_q);
  endtask : xbyte
endmodule : ias_i2c_master
`default_nettype wire

// ---- verif/ias_result_slave_tb.sv ----
/*
  Self-checking bench for the result slave: polling, misses, reads and continuous reads.
  Assumes the master model of ias_i2c_master.sv and shortened conversion counts.
*/
`timescale 1ns/100ps
`default_nettype none
module ias_result_slave_tb;
  import ias_pkg::*;
  localparam logic [6:0] DEV = {4'h6, IAS_ADDR_SEL_DEFAULT};
  logic        clk_in, link_clk, rst_n, sda_oe, sda_o, busy, scl, sda, a;
  logic [11:0] sample, result;
  logic [7:0]  q;
  int          n_errors, tests_run, n_busy;

  ias_result_slave #(.ACQ_CYCLES(4), .CONV_CYCLES(8)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n), .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .sample_in(sample), .result_out(result), .busy_out(busy)
  );
  ias_i2c_master M (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_line_out(sda));
  // one busy pulse for every conversion the link asks for
  always @(posedge busy) n_busy++;

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic addr_rd(input logic exp_ack);
    M.start();
    M.xbyte({DEV, 1'b1}, 1'b1, q, a);
    chk({11'h0, a}, {11'h0, exp_ack});
  endtask : addr_rd
  task automatic t_poll();
    M.start();
    M.xbyte({DEV, 1'b0}, 1'b1, q, a);
    chk({11'h0, a}, 12'h000);
    chk(result, 12'h000);
    sample = 12'h5A3;
    addr_rd(1'b0);
    M.xbyte(8'hFF, 1'b0, q, a);
    chk({4'h0, q}, 12'h005);
    M.xbyte(8'hFF, 1'b1, q, a);
    chk({4'h0, q}, 12'h0A3);
    M.stop();
    chk(result, 12'h5A3);
    $display("test poll and repeated start done");
  endtask : t_poll
  task automatic t_miss();
    logic [6:0] bad [3];
    bad = '{DEV ^ 7'h40, DEV ^ 7'h01, DEV ^ 7'h04};
    for (int k = 0; k < 3; k++) begin
      M.start();
      M.xbyte({bad[k], 1'b1}, 1'b1, q, a);
      chk({11'h0, a}, 12'h001);
      M.xbyte(8'hFF, 1'b1, q, a);
      chk({q, 3'h0, a}, 12'hFF1);
      M.stop();
    end
    chk(result, 12'h5A3);
    $display("test address miss done");
  endtask : t_miss
  task automatic t_read();
    logic [11:0] v [2];
    v = '{12'hFFF, 12'h000};
    for (int k = 0; k < 2; k++) begin
      sample = v[k];
      addr_rd(1'b0);
      M.xbyte(8'hFF, 1'b0, q, a);
      chk({4'h0, q}, {8'h00, v[k][11:8]});
      M.xbyte(8'hFF, 1'b1, q, a);
      chk({4'h0, q}, {4'h0, v[k][7:0]});
      M.stop();
      chk(result, v[k]);
    end
    $display("test read boundaries done");
  endtask : t_read
  task automatic t_cont();
    sample = 12'h3F1;
    addr_rd(1'b0);
    M.xbyte(8'hFF, 1'b0, q, a);
    chk({4'h0, q}, 12'h003);
    sample = 12'hC0E;
    M.xbyte(8'hFF, 1'b0, q, a);
    chk({4'h0, q}, 12'h0F1);
    M.xbyte(8'hFF, 1'b0, q, a);
    chk({4'h0, q}, 12'h00C);
    M.xbyte(8'hFF, 1'b1, q, a);
    chk({4'h0, q}, 12'h00E);
    chk({11'h0, a}, 12'h001);
    M.stop();
    chk(result, 12'hC0E);
    // reads so far asked for nine conversions: one per read address, one per lower-byte lsb
    chk(12'(n_busy), 12'h009);
    $display("test continuous read done");
  endtask : t_cont

  initial begin
    n_errors  = 0;
    tests_run = 0;
    n_busy    = 0;
    rst_n     = 1'b0;
    sample    = 12'h000;
    // core needs 12 cycles, link reset needs a few link edges as well
    repeat (12) @(negedge clk_in);
    repeat (4) @(posedge link_clk);
    @(negedge clk_in);
    chk({9'h0, sda_oe, busy, sda_o}, 12'h000);
    chk(result, 12'h000);
    rst_n = 1'b1;
    $display("test reset done");
    t_poll();
    t_miss();
    t_read();
    t_cont();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end
endmodule : ias_result_slave_tb
`default_nettype wire
